// ==== rtl/color_seq_pkg.sv ====
/*
  Constants, state codes and the overview of the color sequence control.
  Assumes a single 25 MHz clock and static mode pins from the controller.
*/
// Overview of operation
// [RL1] Double-rate drives two lines from stored samples
// [RL2] Controller ties mode pins static to panel
// [RL3] Mode pins choose video input per store
// [RL4] Per-field inversion: one polarity per field, flips
// [RL5] Per-line inversion: odd positive, reverse next field
// [RL6] Mode pin encoding per filter and rate
// [RL7] Controller routes positive and inverted RGB inputs
// [RL8] Mosaic double-rate: outputs rotate colors per line
// [RL9] Other mosaic, stripe, bidirectional: same routing
// [RL10] Unicolor single-rate: controller shifts clock phase
// [RL11] Bicolor single-rate: controller shifts clock phase
// [RL12] Bicolor single-rate: routing differs per field
// [RL13] Bicolor single-rate: outputs alternate two colors
// [RL14] Bicolor single-rate field routing given by controller
// [RL15] Triangular double-rate: controller delays video
// [RL16] Unicolor double-rate: each output fixed color
// [RL17] Interlaced triangular double: field sets start polarity
// [RL18] Non-interlaced triangular double: always start positive
// [RL19] Unicolor double interlaced routing by controller
// [RL20] Sequencing restarts on both field edges
// [RL21] Line advance rising edge steps the sequence
// [RL22] Drive rate pin selects double or single rate
// [RL23] Mode pins take effect at field boundaries
// [RL24] Line parity clears per field, toggles per line
package color_seq_pkg;

  typedef enum logic [1:0] {
    MODE_MOSAIC = 2'b00,
    MODE_FIXED = 2'b01,
    MODE_BICOLOR = 2'b10,
    MODE_TRIDOUBLE = 2'b11
  } mode_t;

  localparam int SYNC_WIDTH = 7;
  localparam int NUM_OUTPUTS = 3;
  localparam logic [1:0] PHASE_LAST = 2'h2;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic PARITY_RESET = 1'b0;
  localparam logic FIRST_FIELD_RESET = 1'b1;
  localparam logic [1:0] STORE_A = 2'h0;
  localparam logic [1:0] STORE_C = 2'h2;
  localparam logic [1:0] STORE_D = 2'h3;
  localparam logic [1:0] SOURCE_RED = 2'h0;
  localparam logic [1:0] SOURCE_GREEN = 2'h1;
  localparam logic [1:0] SOURCE_BLUE = 2'h2;
  // Bit positions inside the synchronised pin group
  localparam int PIN_FILTER1 = 6;
  localparam int PIN_FILTER2 = 5;
  localparam int PIN_RATE = 4;
  localparam int PIN_INVERT = 3;
  localparam int PIN_INTERLACE = 2;
  localparam int PIN_FIELD = 1;
  localparam int PIN_LINE = 0;

endpackage : color_seq_pkg

// ==== rtl/lcd_color_sequence_control.sv ====
/*
  Color sequence and inversion control: picks the video input, polarity
  and sample-and-hold stores for the three outputs of each column group.
  Assumes the timing controller routes and delays the video itself.
*/
`timescale 1ns/1ps
module lcd_color_sequence_control
  import color_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic filterSelect1,
  input wire logic filterSelect2,
  input wire logic driveRateSelect,
  input wire logic inversionSelect,
  input wire logic interlaceSelect,
  input wire logic fieldId,
  input wire logic lineAdvance,
  output logic [1:0] columnOutFirstSrc,
  output logic [1:0] columnOutSecondSrc,
  output logic [1:0] columnOutThirdSrc,
  output logic columnOutFirstNeg,
  output logic columnOutSecondNeg,
  output logic columnOutThirdNeg,
  output logic [1:0] sampleStore,
  output logic [1:0] readStore,
  output logic doubleRate,
  output logic linePhase
);
  import color_seq_pkg::*;

  typedef struct packed {
    logic fieldSeen;
    logic lineSeen;
    logic firstField;
    logic parity;
    logic [1:0] phase;
    mode_t mode;
    logic rate;
    logic invLine;
    logic interlace;
    logic [NUM_OUTPUTS-1:0][1:0] src;
    logic [NUM_OUTPUTS-1:0] neg;
    logic [1:0] sample;
    logic [1:0] read;
  } state_t;

  state_t st;
  state_t next_st;
  logic [SYNC_WIDTH-1:0] pins;
  logic fieldLvl;
  logic lineLvl;
  logic fieldEdge;
  logic lineRise;

  sync_pair #(.WIDTH(SYNC_WIDTH)) pinSync (
    .clk(clk),
    .rst_b(rst_b),
    .async({filterSelect1, filterSelect2, driveRateSelect, inversionSelect,
            interlaceSelect, fieldId, lineAdvance}),
    .synced(pins)
  );

  assign fieldLvl = pins[PIN_FIELD];
  assign lineLvl = pins[PIN_LINE];
  assign fieldEdge = fieldLvl != st.fieldSeen;
  assign lineRise = lineLvl && !st.lineSeen;

  // Rotate a color code down by d steps, modulo three
  function automatic logic [1:0] rotate3(input logic [1:0] base,
                                         input logic [1:0] d);
    logic [2:0] t;
    t = {1'b0, base} + 3'h3 - {1'b0, d};
    if (t >= 3'h3) begin
      t = t - 3'h3;
    end
    return t[1:0];
  endfunction : rotate3

  function automatic mode_t decode(input logic f1, input logic f2,
                                   input logic dr);
    mode_t m;
    m = MODE_FIXED;
    if (!f1) begin
      m = MODE_MOSAIC;
    end else if (!f2 && dr) begin
      m = MODE_TRIDOUBLE;
    end else if (!f2) begin
      m = MODE_BICOLOR;
    end
    return m;
  endfunction : decode

  always_comb begin
    next_st = st;
    next_st.fieldSeen = fieldLvl;
    next_st.lineSeen = lineLvl;
    if (fieldEdge) begin
      // Restart on either field edge; mode pins latch only here
      next_st.parity = PARITY_RESET; // [RL20] [RL24]
      next_st.phase = PHASE_RESET; // [RL20]
      next_st.firstField = fieldLvl;
      next_st.mode = decode(pins[PIN_FILTER1], pins[PIN_FILTER2],
                            pins[PIN_RATE]); // [RL3] [RL23]
      next_st.rate = pins[PIN_RATE]; // [RL22] [RL23]
      next_st.invLine = pins[PIN_INVERT];
      next_st.interlace = pins[PIN_INTERLACE];
    end else if (lineRise) begin
      next_st.parity = !st.parity; // [RL21] [RL24]
      next_st.phase = (st.phase == PHASE_LAST) ? PHASE_RESET :
                      st.phase + 2'h1; // [RL21]
    end
    if (!rst_b) begin
      next_st = '0;
      next_st.firstField = FIRST_FIELD_RESET;
      next_st.mode = MODE_MOSAIC;
    end
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      unique case (next_st.mode)
        MODE_MOSAIC: begin
          next_st.src[i] = rotate3(2'(i), next_st.phase); // [RL8]
        end
        MODE_FIXED, MODE_BICOLOR, MODE_TRIDOUBLE: begin
          // Bicolor keeps its input; the field routing swaps colors
          next_st.src[i] = 2'(i); // [RL13] [RL16]
        end
      endcase
      if (next_st.mode == MODE_TRIDOUBLE) begin
        next_st.neg[i] = next_st.interlace ?
          (next_st.parity ^ !next_st.firstField) : // [RL17]
          next_st.parity; // [RL18]
      end else if (next_st.invLine || next_st.mode == MODE_BICOLOR) begin
        next_st.neg[i] = next_st.parity ^ !next_st.firstField; // [RL5]
      end else begin
        next_st.neg[i] = !next_st.firstField; // [RL4]
      end
    end
    // Single rate uses A and D only; double rate uses A and C, alternating per line
    if (next_st.rate) begin
      next_st.sample = next_st.parity ? STORE_C : STORE_A; // [RL1]
      next_st.read = next_st.parity ? STORE_A : STORE_C; // [RL1]
    end else begin
      next_st.sample = next_st.parity ? STORE_D : STORE_A;
      next_st.read = next_st.parity ? STORE_A : STORE_D;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign columnOutFirstSrc = st.src[0];
  assign columnOutSecondSrc = st.src[1];
  assign columnOutThirdSrc = st.src[2];
  assign columnOutFirstNeg = st.neg[0];
  assign columnOutSecondNeg = st.neg[1];
  assign columnOutThirdNeg = st.neg[2];
  assign sampleStore = st.sample;
  assign readStore = st.read;
  assign doubleRate = st.rate;
  assign linePhase = st.parity;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence lineStep;
    lineRise && !fieldEdge;
  endsequence

  AST_PARITY_TOGGLE: assert property ( // [RL24] [RL21]
    lineStep |=> linePhase != $past(linePhase))
    else $error("Line parity did not toggle");

  AST_FIELD_RESTART: assert property ( // [RL20]
    fieldEdge |=> !linePhase && st.phase == PHASE_RESET)
    else $error("Field edge did not restart sequence");

  AST_FIELD_POLARITY: assert property ( // [RL4]
    $past(rst_b) && st.mode inside {MODE_MOSAIC, MODE_FIXED} && !st.invLine
    |-> columnOutFirstNeg == !st.firstField &&
        columnOutThirdNeg == columnOutFirstNeg)
    else $error("Per-field polarity wrong");

  AST_LINE_POLARITY: assert property ( // [RL5]
    $past(rst_b) && st.mode != MODE_TRIDOUBLE && st.invLine
    |-> columnOutSecondNeg == (linePhase ^ !st.firstField))
    else $error("Per-line polarity wrong");

  AST_MOSAIC_ROTATE: assert property ( // [RL8]
    st.mode == MODE_MOSAIC ##0 lineStep
    |=> columnOutFirstSrc == $past(columnOutThirdSrc) &&
        columnOutSecondSrc == $past(columnOutFirstSrc))
    else $error("Mosaic color rotation wrong");

  AST_FIXED_COLOR: assert property ( // [RL16] fixed colors, checked in MODE_TRIDOUBLE, not in unicolor MODE_FIXED
    $past(rst_b) && st.mode == MODE_TRIDOUBLE
    |-> columnOutFirstSrc == SOURCE_RED &&
        columnOutSecondSrc == SOURCE_GREEN &&
        columnOutThirdSrc == SOURCE_BLUE)
    else $error("Fixed color outputs wrong");

  AST_BICOLOR_ALT: assert property ( // [RL13]
    $past(rst_b) && st.mode == MODE_BICOLOR
    |-> columnOutFirstSrc == SOURCE_RED &&
        columnOutThirdSrc == SOURCE_BLUE &&
        columnOutFirstNeg == (linePhase ^ !st.firstField))
    else $error("Bicolor alternation wrong");

  AST_TRI_POLARITY: assert property ( // [RL17] [RL18]
    st.mode == MODE_TRIDOUBLE ##0 lineStep
    |=> columnOutFirstNeg == (linePhase ^ (st.interlace && !st.firstField))
        ##0 linePhase != $past(linePhase))
    else $error("Triangular double-rate polarity wrong");

  // Outputs only move on a line step or a field edge
  AST_OUTPUTS_STAND: assert property ( // [RL21]
    !lineRise && !fieldEdge
    |=> $stable(columnOutFirstSrc) && $stable(columnOutThirdNeg) &&
        $stable(sampleStore) && $stable(linePhase))
    else $error("Outputs moved without a line step");

  AST_STORE_SINGLE: assert property ( // [RL22]
    $past(rst_b) && !doubleRate
    |-> {sampleStore, readStore} ==
        (linePhase ? {STORE_D, STORE_A} : {STORE_A, STORE_D}))
    else $error("Single-rate store selection wrong");

  AST_STORE_SPLIT: assert property ( // [RL1]
    $past(rst_b) && doubleRate
    |-> readStore != sampleStore && sampleStore[1] == linePhase)
    else $error("Double-rate store selection wrong");

  AST_RATE_LATCH: assert property ( // [RL22] [RL23]
    fieldEdge |=> doubleRate == $past(pins[PIN_RATE]))
    else $error("Drive rate not latched at field edge");
endmodule : lcd_color_sequence_control

// ==== rtl/sync_pair.sv ====
/*
  Two-flop synchroniser for a group of slow pin levels.
  Assumes the pins change far slower than the clock; bits may skew by one.
*/
`timescale 1ns/1ps
module sync_pair #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st.meta = async;
    next_st.stable = st.meta;
    if (!rst_b) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign synced = st.stable;
endmodule : sync_pair

// ==== tb/lcd_color_sequence_control_tb_top.sv ====
/*
  Bench for the color sequence control: six filter, rate and interlace
  settings, each with and without inversion, through two fields. Assumes the controller model drives pins.
*/
`timescale 1ns/1ps
module lcd_color_sequence_control_tb_top;
  import color_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fs1, fs2, rate, inv, il, fieldId, lineAdvance;
  logic [1:0] src1, src2, src3, sampleStore, readStore;
  logic neg1, neg2, neg3, doubleRate, linePhase;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Mosaic both rates, stripe, bicolor single, triangular double
  logic [4:0] modes [6] = '{5'h04, 5'h08, 5'h18, 5'h10, 5'h15, 5'h14};

  always #20 clk = ~clk;

  panel_timing_ctrl panel_timing_ctrl_i (.clk(clk), .filterSelect1(fs1),
    .filterSelect2(fs2), .driveRateSelect(rate), .inversionSelect(inv),
    .interlaceSelect(il), .fieldId(fieldId), .lineAdvance(lineAdvance));

  lcd_color_sequence_control lcd_color_sequence_control_i (.clk(clk),
    .rst_b(rst_b), .filterSelect1(fs1), .filterSelect2(fs2),
    .driveRateSelect(rate), .inversionSelect(inv), .interlaceSelect(il),
    .fieldId(fieldId), .lineAdvance(lineAdvance),
    .columnOutFirstSrc(src1), .columnOutSecondSrc(src2),
    .columnOutThirdSrc(src3), .columnOutFirstNeg(neg1),
    .columnOutSecondNeg(neg2), .columnOutThirdNeg(neg3),
    .sampleStore(sampleStore), .readStore(readStore),
    .doubleRate(doubleRate), .linePhase(linePhase));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Mode bits are {f1, f2, rate, inversion, interlace}
  function automatic logic [3:0] exp_neg(input logic [4:0] m,
                                         input logic first, input int n);
    logic p, ng;
    p = n[0];
    if (m[4] & !m[3] & (!m[2] | m[0])) ng = p ^ !first;
    else if (m[4] & !m[3]) ng = p;
    else if (m[1]) ng = p ^ !first;
    else ng = !first;
    return {1'b0, {3{ng}}};
  endfunction : exp_neg

  task automatic check_line(input logic [4:0] m, input logic f,
                            input int n);
    int r;
    int rc;
    logic [1:0] far;
    logic [1:0] c1, c2, c3;
    r = m[4] ? 0 : n % 3;
    rc = !m[4] ? n % 3 : (!m[3] && !m[2]) ? n % 2 : 0;
    far = m[2] ? STORE_C : STORE_D;
    c1 = panel_timing_ctrl_i.routed(m, f, neg1, src1);
    c2 = panel_timing_ctrl_i.routed(m, f, neg2, src2);
    c3 = panel_timing_ctrl_i.routed(m, f, neg3, src3);
    check("src", {src1, src2, src3},
      {2'((3 - r) % 3), 2'((4 - r) % 3), 2'((5 - r) % 3)});
    check("color", {c1, c2, c3},
      {2'((3 - rc) % 3), 2'((4 - rc) % 3), 2'((5 - rc) % 3)});
    check("neg", {neg1, neg2, neg3},
      exp_neg(m, f, n));
    check("store",
      {sampleStore, readStore, doubleRate, linePhase},
      {n[0] ? far : STORE_A, n[0] ? STORE_A : far, m[2], n[0]});
  endtask : check_line

  task automatic walk(input logic [4:0] m);
    panel_timing_ctrl_i.set_mode(m);
    for (int f = 1; f >= 0; f--) begin
      panel_timing_ctrl_i.field(f[0]);
      for (int n = 0; n < 4; n++) begin
        if (n > 0) panel_timing_ctrl_i.step_line();
        check_line(m, f[0], n);
      end
    end
  endtask : walk

  // Guards against a hang anywhere in the test sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    check("reset", {src1, src2, src3, neg1, neg2, neg3, sampleStore,
      readStore, doubleRate, linePhase}, 16'h0c0c);
    rst_b = 1'b1;
    foreach (modes[i]) begin
      walk(modes[i]);
      walk(modes[i] | 5'h02);
    end
    panel_timing_ctrl_i.set_mode(5'h04);
    panel_timing_ctrl_i.field(1'b1);
    panel_timing_ctrl_i.step_line();
    panel_timing_ctrl_i.set_mode(5'h10);
    panel_timing_ctrl_i.step_line();
    check_line(5'h04, 1'b1, 2);
    panel_timing_ctrl_i.field(1'b0);
    check_line(5'h10, 1'b0, 0);
    summarize();
  end
endmodule : lcd_color_sequence_control_tb_top

// ==== tb/panel_timing_ctrl.sv ====
/*
  Timing controller model: mode pins, field level and line steps.
  Assumes the bench calls its tasks; pins move on the falling edge.
*/
`timescale 1ns/1ps
module panel_timing_ctrl (
  input wire logic clk,
  output logic filterSelect1,
  output logic filterSelect2,
  output logic driveRateSelect,
  output logic inversionSelect,
  output logic interlaceSelect,
  output logic fieldId,
  output logic lineAdvance
);
  initial begin
    {filterSelect1, filterSelect2, driveRateSelect} = 3'h0;
    {inversionSelect, interlaceSelect, fieldId, lineAdvance} = 4'h0;
  end
  // Color index the controller puts on a video input
  // Delays are the controller's own; only color matters
  function automatic logic [1:0] routed(input logic [4:0] m,
                                        input logic first,
                                        input logic neg,
                                        input logic [1:0] idx);
    logic [1:0] c;
    c = idx;
    // Bicolor single rate swaps routing on odd lines, the same in both fields
    if (m[4] && !m[3] && !m[2] && (neg == first)) begin
      c = (idx == 2'h0) ? 2'h2 : idx - 2'h1;
    end
    return c;
  endfunction : routed
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // Static levels, held well past the synchroniser
  task automatic set_mode(input logic [4:0] m);
    @(negedge clk);
    {filterSelect1, filterSelect2, driveRateSelect} = m[4:2];
    {inversionSelect, interlaceSelect} = m[1:0];
    wait_n(5);
  endtask : set_mode
  // High in first field, low in second
  task automatic field(input logic first);
    @(negedge clk);
    fieldId = first;
    wait_n(5);
  endtask : field
  // Pulse wide enough to survive synchronising
  // Per-line sampling phase shift stays in the controller
  task automatic step_line();
    @(negedge clk);
    lineAdvance = 1'b1;
    wait_n(4);
    lineAdvance = 1'b0;
    wait_n(5);
  endtask : step_line
endmodule : panel_timing_ctrl
